/* File: design/brake_pkg.sv */
package brake_pkg;
  localparam int CLK_NS = 5;
  localparam int DELAY_UNIT_MS = 10;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000000 / CLK_NS;
  localparam int RAMP_STEP_NS = 10000;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_NS;
  localparam int FREQ_W = 16;
  localparam int CUR_W = 11;
  localparam int DLY_W = 10;
  localparam int SEL_W = 5;
  localparam int ADDR_W = 8;
  localparam int RAMP_CNT_W = 12;
  localparam int TICK_CNT_W = 24;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REL_CUR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_REL_DLY = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_REL_FWD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REL_REV = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ENG_DLY = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ENG_FREQ = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CMD_FREQ = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OUT_FREQ = 8'h28;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_MODE = 2;
  localparam int FUNC_OUT2_LSB = 8;
  localparam logic MODE_VF = 1'b0;
  localparam logic MODE_RST = 1'b1;
  localparam logic [SEL_W-1:0] SEL_BRAKE = 5'h13;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h11;
  localparam logic [SEL_W-1:0] SEL_MAX = 5'h13;
  localparam logic [CUR_W-1:0] CUR_RST = 11'h1f4;
  localparam logic [CUR_W-1:0] CUR_MAX = 11'h708;
  localparam logic [DLY_W-1:0] DLY_RST = 10'h064;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e8;
  localparam logic [FREQ_W-1:0] REL_FREQ_RST = 16'h0064;
  localparam logic [FREQ_W-1:0] ENG_FREQ_RST = 16'h00c8;
  localparam logic [FREQ_W-1:0] CMD_FREQ_RST = 16'h1770;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REL_RAMP, ST_REL_WAIT, ST_REL_DELAY, ST_RUN, ST_ENG_RAMP, ST_ENG_DELAY
  } state_e;
  function automatic logic is_brake_sel(input logic [SEL_W-1:0] sel);
    return sel == SEL_BRAKE;
  endfunction
  function automatic logic [SEL_W-1:0] clamp_sel(input logic [SEL_W-1:0] v);
    return (v > SEL_MAX) ? SEL_MAX : v;
  endfunction
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [DLY_W-1:0] v);
    return (v > DLY_MAX) ? DLY_MAX : v;
  endfunction
endpackage

/* File: design/freq_ramp.sv */
`timescale 1ns/1ps
module freq_ramp import brake_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [FREQ_W-1:0] target,
  input wire logic hold,
  input wire logic zero,
  // output
  output logic [FREQ_W-1:0] freq_r,
  output logic at_target
);
  logic [RAMP_CNT_W-1:0] pre_r;
  logic step;

  assign step = (pre_r == RAMP_CNT_W'(RAMP_STEP_CYC - 1));
  assign at_target = (freq_r == target);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (step || hold) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // one 0.01 Hz step per tick in either direction; zero overrides everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r <= '0;
    end else if (zero) begin
      freq_r <= '0;
    end else if (step && !hold && !at_target) begin
      if (freq_r < target) begin
        freq_r <= freq_r + 1'b1;
      end else begin
        freq_r <= freq_r - 1'b1;
      end
    end
  end
endmodule // freq_ramp

/* File: design/delay_timer.sv */
`timescale 1ns/1ps
module delay_timer import brake_pkg::*; #(
  parameter int TICK_CYC = DELAY_UNIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [DLY_W-1:0] units,
  output logic done
);
  logic [TICK_CNT_W-1:0] pre_r;
  logic [DLY_W-1:0] cnt_r;
  logic tick;

  assign tick = (pre_r == TICK_CNT_W'(TICK_CYC - 1));
  // a zero setting completes at once
  assign done = run && (cnt_r >= units);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (!run || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (tick && !done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // delay_timer

/* File: design/brake_sequence_controller.sv */
// Operation
// - Sequencing runs only while the control mode select is 0 (V/F steady); otherwise inactive.
// - Brake settings act only when the relay or output 2 selector is 19; selectors 0-19, reset 17.
// - While sequencing is enabled, DC braking and start dwell are suppressed.
// - A run from standstill ramps only to the release frequency of the commanded direction.
// - At release frequency, release is signalled once motor current reaches the release current.
// - After release, frequency is held for the release delay before acceleration resumes.
// - On stop, deceleration halts at the engage frequency and brake engage is signalled.
// - After engage, the engage frequency is held for the engage delay, then set to zero.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module brake_sequence_controller import brake_pkg::*; #(
  parameter int TICK_CYC = DELAY_UNIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side
  input wire logic [CUR_W-1:0] motor_current,
  output logic [FREQ_W-1:0] out_freq,
  output logic out_dir,
  output logic brake_relay,
  output logic brake_out2,
  output logic dc_brake_allow,
  output logic dwell_allow
);
  logic run_r, dir_cmd_r, mode_r;
  logic [SEL_W-1:0] relay_sel_r, out2_sel_r;
  logic [CUR_W-1:0] rel_cur_r;
  logic [DLY_W-1:0] rel_dly_r, eng_dly_r;
  logic [FREQ_W-1:0] rel_fwd_r, rel_rev_r, eng_freq_r, cmd_freq_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  state_e state_r;
  logic dir_r, release_r;
  logic brake_relay_r, brake_out2_r, dc_allow_r, dwell_allow_r;
  logic seq_en, wr_en, setup, hit;
  logic [FREQ_W-1:0] ramp_target, rel_target, freq;
  logic ramp_hold, ramp_zero, at_target, tmr_run, tmr_done;
  logic [DLY_W-1:0] tmr_units;
  logic [31:0] rd_mux;

  assign seq_en = (mode_r == MODE_VF)
    && (is_brake_sel(relay_sel_r) || is_brake_sel(out2_sel_r));
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;

  // no wait state: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      OFS_CTRL: rd_mux = {29'h0, mode_r, dir_cmd_r, run_r};
      OFS_FUNC: rd_mux = {19'h0, out2_sel_r, 3'h0, relay_sel_r};
      OFS_REL_CUR: rd_mux = {21'h0, rel_cur_r};
      OFS_REL_DLY: rd_mux = {22'h0, rel_dly_r};
      OFS_REL_FWD: rd_mux = {16'h0, rel_fwd_r};
      OFS_REL_REV: rd_mux = {16'h0, rel_rev_r};
      OFS_ENG_DLY: rd_mux = {22'h0, eng_dly_r};
      OFS_ENG_FREQ: rd_mux = {16'h0, eng_freq_r};
      OFS_CMD_FREQ: rd_mux = {16'h0, cmd_freq_r};
      OFS_STATUS: rd_mux = {26'h0, seq_en, release_r, dir_r, 3'(state_r)};
      OFS_OUT_FREQ: rd_mux = {16'h0, freq};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0 : rd_mux;
      pslverr_r <= !hit;
    end else if (!psel) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
  end

  // settings; out-of-range writes saturate at the documented maxima
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      dir_cmd_r <= 1'b0;
      mode_r <= MODE_RST;
      relay_sel_r <= SEL_RST;
      out2_sel_r <= SEL_RST;
      rel_cur_r <= CUR_RST;
      rel_dly_r <= DLY_RST;
      rel_fwd_r <= REL_FREQ_RST;
      rel_rev_r <= REL_FREQ_RST;
      eng_dly_r <= DLY_RST;
      eng_freq_r <= ENG_FREQ_RST;
      cmd_freq_r <= CMD_FREQ_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          run_r <= pwdata[CTRL_RUN];
          dir_cmd_r <= pwdata[CTRL_DIR];
          mode_r <= pwdata[CTRL_MODE];
        end
        OFS_FUNC: begin
          relay_sel_r <= clamp_sel(pwdata[SEL_W-1:0]);
          out2_sel_r <= clamp_sel(pwdata[FUNC_OUT2_LSB +: SEL_W]);
        end
        OFS_REL_CUR: rel_cur_r <= (pwdata[CUR_W-1:0] > CUR_MAX) ? CUR_MAX : pwdata[CUR_W-1:0];
        OFS_REL_DLY: rel_dly_r <= clamp_dly(pwdata[DLY_W-1:0]);
        OFS_REL_FWD: rel_fwd_r <= pwdata[FREQ_W-1:0];
        OFS_REL_REV: rel_rev_r <= pwdata[FREQ_W-1:0];
        OFS_ENG_DLY: eng_dly_r <= clamp_dly(pwdata[DLY_W-1:0]);
        OFS_ENG_FREQ: eng_freq_r <= pwdata[FREQ_W-1:0];
        OFS_CMD_FREQ: cmd_freq_r <= pwdata[FREQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign rel_target = dir_r ? rel_rev_r : rel_fwd_r;

  always_comb begin
    ramp_target = '0;
    ramp_hold = 1'b0;
    ramp_zero = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        // plain ramp when the sequence is disabled
        ramp_target = (!seq_en && run_r) ? cmd_freq_r : '0;
        ramp_zero = seq_en && !run_r;
      end
      ST_REL_RAMP: ramp_target = rel_target;
      ST_REL_WAIT: begin
        ramp_target = rel_target;
        ramp_hold = 1'b1;
      end
      ST_REL_DELAY: begin
        ramp_target = rel_target;
        ramp_hold = 1'b1;
      end
      ST_RUN: ramp_target = cmd_freq_r;
      ST_ENG_RAMP: ramp_target = eng_freq_r;
      ST_ENG_DELAY: begin
        ramp_target = eng_freq_r;
        ramp_hold = 1'b1;
        ramp_zero = tmr_done;
      end
    endcase
  end

  assign tmr_run = (state_r == ST_REL_DELAY) || (state_r == ST_ENG_DELAY);
  assign tmr_units = (state_r == ST_ENG_DELAY) ? eng_dly_r : rel_dly_r;

  freq_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .target(ramp_target),
    .hold(ramp_hold),
    .zero(ramp_zero),
    .freq_r(freq),
    .at_target(at_target)
  );

  delay_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(tmr_run),
    .units(tmr_units),
    .done(tmr_done)
  );

  // a stop before release simply drops the output; the brake never opened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      dir_r <= 1'b0;
    end else if (!seq_en) begin
      state_r <= ST_IDLE;
      if (freq == '0) begin
        dir_r <= dir_cmd_r;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: if (run_r) begin
          dir_r <= dir_cmd_r;
          state_r <= ST_REL_RAMP;
        end
        ST_REL_RAMP: if (!run_r) begin
          state_r <= ST_IDLE;
        end else if (at_target) begin
          state_r <= ST_REL_WAIT;
        end
        ST_REL_WAIT: if (!run_r) begin
          state_r <= ST_IDLE;
        end else if (motor_current >= rel_cur_r) begin
          state_r <= ST_REL_DELAY;
        end
        ST_REL_DELAY: if (tmr_done) begin
          state_r <= run_r ? ST_RUN : ST_ENG_RAMP;
        end
        ST_RUN: if (!run_r) begin
          state_r <= ST_ENG_RAMP;
        end
        // stopping at the engage point relies on release below engage frequency
        ST_ENG_RAMP: if (freq <= eng_freq_r) begin
          state_r <= ST_ENG_DELAY;
        end
        ST_ENG_DELAY: if (tmr_done) begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_r <= 1'b0;
    end else if (!seq_en || state_r == ST_IDLE) begin
      release_r <= 1'b0;
    end else if (state_r == ST_REL_WAIT && motor_current >= rel_cur_r) begin
      release_r <= 1'b1;
    end else if (state_r == ST_ENG_RAMP && freq <= eng_freq_r) begin
      release_r <= 1'b0;
    end
  end

  // terminals follow one cycle after the internal release flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_relay_r <= 1'b0;
      brake_out2_r <= 1'b0;
      dc_allow_r <= 1'b1;
      dwell_allow_r <= 1'b1;
    end else begin
      brake_relay_r <= seq_en && is_brake_sel(relay_sel_r) && release_r;
      brake_out2_r <= seq_en && is_brake_sel(out2_sel_r) && release_r;
      dc_allow_r <= !seq_en;
      dwell_allow_r <= !seq_en;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign out_freq = freq;
  assign out_dir = dir_r;
  assign brake_relay = brake_relay_r;
  assign brake_out2 = brake_out2_r;
  assign dc_brake_allow = dc_allow_r;
  assign dwell_allow = dwell_allow_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mode_gate: assert property (mode_r != MODE_VF |=> state_r == ST_IDLE && !release_r)
    else $error("sequence active outside v/f mode");
  chk_sel_gate: assert property (!is_brake_sel(relay_sel_r) |=> !brake_relay_r)
    else $error("relay driven without brake function selected");
  chk_dc_suppress: assert property (seq_en |=> !dc_brake_allow && !dwell_allow)
    else $error("dc brake or dwell allowed while sequencing");
  chk_release_freq: assert property (state_r == ST_REL_WAIT |-> freq == rel_target)
    else $error("release wait at wrong frequency");
  chk_release_cur: assert property ($rose(release_r) |-> $past(motor_current) >= $past(rel_cur_r))
    else $error("release without enough current");
  chk_release_hold: assert property (state_r == ST_REL_DELAY ##1 state_r == ST_REL_DELAY
    |-> $stable(freq))
    else $error("frequency moved during release delay");
  chk_engage_point: assert property (state_r == ST_ENG_DELAY |-> !release_r ##1
    !brake_relay_r && !brake_out2_r)
    else $error("brake not engaged at engage point");
  chk_engage_zero: assert property (state_r == ST_ENG_DELAY && tmr_done |=> freq == '0)
    else $error("frequency not zero after engage delay");
  chk_stop_engaged: assert property (state_r == ST_IDLE |=> !brake_relay_r && !brake_out2_r)
    else $error("brake released while stopped");

  cov_release: cover property (state_r == ST_REL_DELAY ##1 state_r == ST_RUN);
  cov_engage: cover property (state_r == ST_ENG_DELAY ##1 state_r == ST_IDLE);
  cov_abort: cover property (state_r == ST_REL_WAIT ##1 state_r == ST_IDLE);
endmodule // brake_sequence_controller

/* File: tb/motor_load.sv */
`timescale 1ns/1ps
// motor and brake stand-in: current flows only while a frequency is driven
module motor_load import brake_pkg::*; (
  // clock
  input wire logic pclk,
  // drive side
  input wire logic [FREQ_W-1:0] out_freq,
  input wire logic [CUR_W-1:0] load_level,
  output logic [CUR_W-1:0] motor_current
);
  always_ff @(posedge pclk) begin
    motor_current <= (out_freq != '0) ? load_level : '0;
  end
endmodule // motor_load

/* File: tb/brake_sequence_controller_tb.sv */
`timescale 1ns/1ps
module brake_sequence_controller_tb import brake_pkg::*;;
  // clock and reset
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  // apb
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // drive side
  logic [CUR_W-1:0] motor_current;
  logic [CUR_W-1:0] load_level = '0;
  logic [FREQ_W-1:0] out_freq;
  logic out_dir;
  logic brake_relay;
  logic brake_out2;
  logic dc_brake_allow;
  logic dwell_allow;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] rd_q;
  logic rd_e;

  always #2.5 pclk = ~pclk;

  brake_sequence_controller #(.TICK_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_current(motor_current),
    .out_freq(out_freq), .out_dir(out_dir), .brake_relay(brake_relay),
    .brake_out2(brake_out2), .dc_brake_allow(dc_brake_allow), .dwell_allow(dwell_allow)
  );

  motor_load u_load (
    .pclk(pclk), .out_freq(out_freq), .load_level(load_level),
    .motor_current(motor_current)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle before each setup keeps every signal to one assignment per step
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    rd_e = pslverr;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask

  // bounded wait; running out counts as a mismatch
  task automatic wait_freq(input logic [FREQ_W-1:0] f, input int lim);
    int n;
    n = 0;
    while (out_freq !== f && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(out_freq), 32'(f));
  endtask

  task automatic wait_rel(input logic v, input int lim);
    int n;
    n = 0;
    while (brake_relay !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(brake_relay), 32'(v));
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the bounded waits of the test sum to about 60k cycles; this leaves some margin
  initial begin
    repeat (70000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h4);
    rd(OFS_FUNC, 32'h1111);
    chk(32'(dc_brake_allow), 32'h1);
    rd(8'h30, 32'h0);
    chk(32'(rd_e), 32'h1);
    // release below engage, as the configuring side must keep
    wr(OFS_REL_FWD, 32'h3);
    wr(OFS_REL_REV, 32'h4);
    wr(OFS_ENG_FREQ, 32'h5);
    wr(OFS_REL_DLY, 32'h2);
    wr(OFS_ENG_DLY, 32'h2);
    wr(OFS_REL_CUR, 32'h64);
    wr(OFS_CMD_FREQ, 32'h8);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    chk(32'(dwell_allow), 32'h1);
    wr(OFS_FUNC, 32'h1f1f);
    rd(OFS_FUNC, 32'h1313);
    rd(OFS_STATUS, 32'h20);
    chk({dc_brake_allow, dwell_allow}, 32'h0);
    // forward: current one step short of the release level first
    load_level <= 11'd99;
    wr(OFS_CTRL, 32'h1);
    wait_freq(16'h3, 8000);
    repeat (4000) @(posedge pclk);
    chk(32'(out_freq), 32'h3);
    chk({brake_relay, brake_out2}, 32'h0);
    load_level <= 11'd100;
    wait_rel(1'b1, 10);
    chk(32'(brake_out2), 32'h1);
    repeat (30) @(posedge pclk);
    chk(32'(out_freq), 32'h3);
    wait_freq(16'h4, 2100);
    wait_freq(16'h8, 9000);
    wr(OFS_CTRL, 32'h0);
    wait_rel(1'b0, 7000);
    chk(32'(out_freq), 32'h5);
    repeat (20) @(posedge pclk);
    chk(32'(out_freq), 32'h5);
    wait_freq(16'h0, 60);
    rd(OFS_STATUS, 32'h20);
    // reverse, then run withdrawn before the current arrives
    load_level <= 11'd0;
    wr(OFS_CTRL, 32'h3);
    wait_freq(16'h4, 9000);
    repeat (3000) @(posedge pclk);
    chk({out_freq, out_dir}, {16'h4, 1'b1});
    chk(32'(brake_relay), 32'h0);
    wr(OFS_CTRL, 32'h2);
    wait_freq(16'h0, 10);
    chk(32'(brake_relay), 32'h0);
    // other control mode: plain ramp, no hold at the release frequency
    wr(OFS_CMD_FREQ, 32'h4);
    wr(OFS_CTRL, 32'h4);
    // mode lands at the write edge, the allow flop follows one edge later
    repeat (2) @(posedge pclk);
    chk(32'(dc_brake_allow), 32'h1);
    wr(OFS_CTRL, 32'h5);
    wait_freq(16'h4, 8200);
    chk(32'(brake_relay), 32'h0);
    wr(OFS_CTRL, 32'h4);
    wait_freq(16'h0, 8200);
    conclude();
  end
endmodule // brake_sequence_controller_tb
